// *** core/pmc_consts.svh ***
// Constants for the power management configuration register bank
// How it works
// - Index at base, data at base plus one
// - Index resets zero, upper five bits zero
// - Data port reaches register selected by index
// - Function enable A gates device activation
// - Enable A bits: kbd, rtc, floppy, lpt, uarts
// - Enable B bits 0-2 gate chip selects
// - Enable B bit 7 gates GPIO ports
// - Float bit ORed with device float bit
// - Float bits: floppy, lpt, uart2, uart1
// - Clock control loaded from the two straps after reset
// - Clock control low bits select clock source
// - Clock control bit 2 enables multiplier
// - Clock control bit 7 reads multiplier valid
// - Multiplier frozen and invalid until stable
// - Clock gate bits ANDed with device bits
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH
`define PMC_PORT_INDEX      1'b0
`define PMC_PORT_DATA       1'b1
`define PMC_IDX_FEN_A       3'h0
`define PMC_IDX_FEN_B       3'h1
`define PMC_IDX_FLOAT       3'h2
`define PMC_IDX_CLK         3'h3
`define PMC_IDX_GATE        3'h4
`define PMC_RST_INDEX       3'h0
`define PMC_RST_FEN_A       8'hFF
`define PMC_RST_FEN_B       8'hFF
`define PMC_RST_FLOAT       8'h00
`define PMC_RST_GATE        8'h0E
`define PMC_MASK_FEN_A      8'h7D
`define PMC_MASK_FEN_B      8'h87
`define PMC_MASK_FLOAT      8'h78
`define PMC_MASK_CLK_WR     8'h07
`define PMC_MASK_GATE_WR    8'h0E
`define PMC_CLK_SRC_MULT    2'h3
`define PMC_BASE_LSB_ZERO   1'b0
`define PMC_FEN_B_GPIO      7
`define PMC_CLK_EN_BIT      2
`define PMC_FEN_A_POS       '{0, 2, 3, 4, 5, 6}
`define PMC_FLOAT_POS       '{0, 0, 3, 4, 5, 6}
`define PMC_FLOAT_HAS       6'h3C
`define PMC_GATE_POS        '{0, 0, 0, 1, 2, 3}
`define PMC_GATE_HAS        6'h38
`endif

// *** core/pmc_pkg.sv ***
// Types for the power management configuration register bank
package pmc_pkg;
	// Per-device enable, float or clock vectors for peripherals
	typedef struct packed {
		logic uart1;
		logic uart2;
		logic lpt;
		logic floppy;
		logic rtc;
		logic keyboard;
	} pmc_dev_t;
	// Host bus access to the index/data port pair
	typedef struct packed {
		logic [15:0] addr;
		logic        rd;
		logic        wr;
		logic [7:0]  wdata;
	} pmc_bus_t;
	// Stages of the multiplier start-up tracking
	typedef enum logic [1:0] {
		PMC_MULT_OFF,
		PMC_MULT_WAIT,
		PMC_MULT_RUN
	} pmc_mult_t;
endpackage

// *** core/pmc_regs.sv ***
// Power management index/data register bank with device gating outputs
`include "pmc_consts.svh"
module pmc_regs #(
	parameter int STABLE_CYCLES = 300000 // Multiplier stabilisation, 1.5 ms at 200 MHz
) (
	input  wire logic               clock_in,
	input  wire logic               nrst_in,
	input  wire pmc_pkg::pmc_bus_t  bus_in,
	input  wire logic [15:0]        base_addr_in,
	input  wire logic               strap_clock_a_in,
	input  wire logic               strap_clock_b_in,
	input  wire logic               osc_running_in,
	input  wire pmc_pkg::pmc_dev_t  dev_activate_in,
	input  wire logic               gpio_activate_in,
	input  wire logic [2:0]         chip_select_match_in,
	input  wire pmc_pkg::pmc_dev_t  dev_float_cfg_in,
	input  wire pmc_pkg::pmc_dev_t  dev_clock_cfg_in,
	input  wire logic [1:0]         uart_busy_in,
	output logic [7:0]              rdata_out,
	output pmc_pkg::pmc_dev_t       dev_active_out,
	output logic                    gpio_active_out,
	output logic [2:0]              chip_select_out,
	output pmc_pkg::pmc_dev_t       dev_float_out,
	output pmc_pkg::pmc_dev_t       dev_clock_out,
	output logic [1:0]              clock_source_out,
	output logic                    mult_enable_out,
	output logic                    mult_clock_run_out
);
	import pmc_pkg::*;

	// Theory of operation
	// The host reaches this bank through two byte ports. The even port holds
	// a three bit pointer, the odd port reads or writes the register that the
	// pointer selects. An odd base address disables the decode entirely, so
	// a misprogrammed base can never alias the pair onto a foreign register.
	//
	// Writes land on the clock edge that sees the write strobe. Reads are
	// captured into the read data flop on the edge that sees the read strobe
	// and stand there until the next read of this port pair, so a host that
	// samples late still sees its own data.
	//
	// Reserved bits are masked on the way in, never on the way out. The
	// stored copy is therefore always clean and every consumer of a stored
	// bit may use it directly without a second mask.
	//
	// The clock control register resets to zero. Its source and
	// multiplier enable bits are loaded from the two straps on the first
	// edge after reset release. Until that edge the bank still answers, but
	// the first host access is only expected one edge later.
	//
	// The multiplier tracker starts on a rising edge of the enable bit,
	// including the one produced by the strap load. It counts only while
	// the slow oscillator runs, so a stopped oscillator simply stretches
	// the wait. Clearing the enable drops the valid flag on the next edge.
	// The counter restarts from zero on every new enable, never resumes.
	//
	// Every output toward the peripherals is a registered level, one clock
	// behind the register or input that feeds it. Enables gate by AND, the
	// float bits combine by OR with each device's own float request.
	//
	// Limitation: the busy flags in the clock gate register are shown live
	// from the inputs; they are not latched and may change between reads.
	// Limitation: a write of the reserved source code is stored as written;
	// the clock switch downstream must treat it as the external 24 MHz input.

	localparam int             DEV_N = $bits(pmc_dev_t);
	localparam int             FEN_POS   [DEV_N] = `PMC_FEN_A_POS;
	localparam int             FLOAT_POS [DEV_N] = `PMC_FLOAT_POS;
	localparam int             GATE_POS  [DEV_N] = `PMC_GATE_POS;
	localparam logic [DEV_N-1:0] FLOAT_HAS = `PMC_FLOAT_HAS;
	localparam logic [DEV_N-1:0] GATE_HAS  = `PMC_GATE_HAS;

	localparam int CNT_W = $clog2(STABLE_CYCLES + 1);

	initial begin
		if (STABLE_CYCLES < 1)
			$error("STABLE_CYCLES must be at least one");
	end

	logic [2:0]  index;
	logic [7:0]  fen_a;
	logic [7:0]  fen_b;
	logic [7:0]  float_ctl;
	logic [2:0]  clk_ctl;
	logic [7:0]  gate_ctl;
	logic        strap_taken;
	logic        mult_valid;
	logic        mult_en_q;
	pmc_mult_t   mult_state;
	logic [CNT_W-1:0] mult_cnt;
	logic        hit;
	logic        wr_index;
	logic        wr_data;
	logic [7:0]  next_rdata;
	pmc_dev_t    next_active;
	pmc_dev_t    next_float;
	pmc_dev_t    next_clock;

	// Port decode: index at base, data at base plus one
	assign hit      = (bus_in.addr[15:1] == base_addr_in[15:1]) && (base_addr_in[0] == `PMC_BASE_LSB_ZERO);
	assign wr_index = hit && bus_in.wr && (bus_in.addr[0] == `PMC_PORT_INDEX);
	assign wr_data  = hit && bus_in.wr && (bus_in.addr[0] == `PMC_PORT_DATA);

	// Index register, only three bits stored
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in)
			index <= `PMC_RST_INDEX;
		else if (wr_index)
			index <= bus_in.wdata[2:0];
	end

	// Function enable A, reserved bits stay zero
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in)
			fen_a <= `PMC_RST_FEN_A & `PMC_MASK_FEN_A;
		else if (wr_data && index == `PMC_IDX_FEN_A)
			fen_a <= bus_in.wdata & `PMC_MASK_FEN_A;
	end

	// Function enable B, reserved bits stay zero
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in)
			fen_b <= `PMC_RST_FEN_B & `PMC_MASK_FEN_B;
		else if (wr_data && index == `PMC_IDX_FEN_B)
			fen_b <= bus_in.wdata & `PMC_MASK_FEN_B;
	end

	// Float control register
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in)
			float_ctl <= `PMC_RST_FLOAT;
		else if (wr_data && index == `PMC_IDX_FLOAT)
			float_ctl <= bus_in.wdata & `PMC_MASK_FLOAT;
	end

	// Clock gate register, busy bits are never stored
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in)
			gate_ctl <= `PMC_RST_GATE;
		else if (wr_data && index == `PMC_IDX_GATE)
			gate_ctl <= bus_in.wdata & `PMC_MASK_GATE_WR;
	end

	// Clock control: straps loaded on first edge after reset release
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			clk_ctl     <= 3'h0;
			strap_taken <= 1'b0;
		end else if (!strap_taken) begin
			strap_taken <= 1'b1;
			clk_ctl[1:0] <= {strap_clock_b_in, strap_clock_a_in};
			clk_ctl[2]   <= strap_clock_a_in & strap_clock_b_in;
		end else if (wr_data && index == `PMC_IDX_CLK) begin
			clk_ctl <= 3'(bus_in.wdata & `PMC_MASK_CLK_WR);
		end
	end

	// Multiplier start-up: frozen and invalid until stable period ends
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			mult_state <= PMC_MULT_OFF;
			mult_cnt   <= '0;
			mult_valid <= 1'b0;
			mult_en_q  <= 1'b0;
		end else begin
			mult_en_q <= clk_ctl[2];
			case (mult_state)
				PMC_MULT_OFF: begin
					mult_valid <= 1'b0;
					mult_cnt   <= '0;
					if (clk_ctl[2] && !mult_en_q)
						mult_state <= PMC_MULT_WAIT;
				end
				PMC_MULT_WAIT: begin
					if (!clk_ctl[2]) begin
						mult_state <= PMC_MULT_OFF;
					end else if (osc_running_in) begin
						if (mult_cnt == CNT_W'(STABLE_CYCLES - 1)) begin
							mult_state <= PMC_MULT_RUN;
							mult_valid <= 1'b1;
						end else begin
							mult_cnt <= mult_cnt + 1'b1;
						end
					end
				end
				PMC_MULT_RUN: begin
					if (!clk_ctl[2]) begin
						mult_state <= PMC_MULT_OFF;
						mult_valid <= 1'b0;
					end
				end
				default: mult_state <= PMC_MULT_OFF;
			endcase
		end
	end

	// Read mux for the index and data ports
	always_comb begin
		next_rdata = 8'h00;
		if (bus_in.addr[0] == `PMC_PORT_INDEX)
			next_rdata = {5'h00, index};
		else begin
			case (index)
				`PMC_IDX_FEN_A: next_rdata = fen_a;
				`PMC_IDX_FEN_B: next_rdata = fen_b;
				`PMC_IDX_FLOAT: next_rdata = float_ctl;
				`PMC_IDX_CLK:   next_rdata = {mult_valid, 4'h0, clk_ctl};
				`PMC_IDX_GATE:  next_rdata = {uart_busy_in[0], uart_busy_in[1], gate_ctl[5:0]};
				default:        next_rdata = 8'h00;
			endcase
		end
	end

	// Registered read data, held when not addressed
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in)
			rdata_out <= 8'h00;
		else if (hit && bus_in.rd)
			rdata_out <= next_rdata;
	end

	// Per-device next values, one slice per peripheral
	for (genvar g = 0; g < DEV_N; g++) begin : g_dev
		// A cleared enable bit overrides the device's own activate bit
		assign next_active[g] = fen_a[FEN_POS[g]] & dev_activate_in[g];
		if (FLOAT_HAS[g]) begin : g_flt
			assign next_float[g] = float_ctl[FLOAT_POS[g]] | dev_float_cfg_in[g];
		end else begin : g_flt_own
			assign next_float[g] = dev_float_cfg_in[g];
		end
		if (GATE_HAS[g]) begin : g_gate
			assign next_clock[g] = gate_ctl[GATE_POS[g]] & dev_clock_cfg_in[g];
		end else begin : g_gate_own
			assign next_clock[g] = dev_clock_cfg_in[g];
		end
	end

	// Activation outputs: devices, GPIO ports and chip selects
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			dev_active_out  <= '0;
			gpio_active_out <= 1'b0;
			chip_select_out <= 3'h0;
		end else begin
			dev_active_out  <= next_active;
			gpio_active_out <= fen_b[`PMC_FEN_B_GPIO] & gpio_activate_in;
			chip_select_out <= fen_b[2:0] & chip_select_match_in;
		end
	end

	// Float requests toward the device pins
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in)
			dev_float_out <= '0;
		else
			dev_float_out <= next_float;
	end

	// Device clock gates
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in)
			dev_clock_out <= '0;
		else
			dev_clock_out <= next_clock;
	end

	// Clock source, multiplier enable and multiplier run toward the clock switch
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			clock_source_out   <= 2'h0;
			mult_enable_out    <= 1'b0;
			mult_clock_run_out <= 1'b0;
		end else begin
			clock_source_out   <= clk_ctl[1:0];
			mult_enable_out    <= clk_ctl[`PMC_CLK_EN_BIT];
			mult_clock_run_out <= mult_valid;
		end
	end

endmodule // pmc_regs

// *** sim/pmc_regs_props.sv ***
// Concurrent checks on the power management register bank ports
module pmc_regs_props #(
	parameter int STABLE_CYCLES = 20
) (
	input wire logic              clock_in,
	input wire logic              nrst_in,
	input wire pmc_pkg::pmc_bus_t bus_in,
	input wire logic [15:0]       base_addr_in,
	input wire pmc_pkg::pmc_dev_t dev_activate_in,
	input wire logic              gpio_activate_in,
	input wire logic [2:0]        chip_select_match_in,
	input wire pmc_pkg::pmc_dev_t dev_clock_cfg_in,
	input wire logic [7:0]        rdata_out,
	input wire pmc_pkg::pmc_dev_t dev_active_out,
	input wire logic              gpio_active_out,
	input wire logic [2:0]        chip_select_out,
	input wire pmc_pkg::pmc_dev_t dev_clock_out,
	input wire logic              mult_enable_out,
	input wire logic              mult_clock_run_out
);
	logic       hit;
	logic       rd_hit;
	logic       idx_rd;
	logic       dat_rd;
	logic [2:0] idx;
	// Decode host accesses to the port pair
	assign hit = bus_in.addr[15:1] == base_addr_in[15:1];
	assign rd_hit = bus_in.rd && hit;
	assign idx_rd = rd_hit && !bus_in.addr[0];
	assign dat_rd = rd_hit && bus_in.addr[0];
	// Shadow of the index port
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			idx <= 3'h0;
		end else if (bus_in.wr && hit && !bus_in.addr[0]) begin
			idx <= bus_in.wdata[2:0];
		end
	end
	default clocking @(posedge clock_in); endclocking
	default disable iff (!nrst_in);
	act_gate_a: assert property ((dev_active_out & ~$past(dev_activate_in)) == 6'h00)
		else $error("device active without activate");
	gpio_gate_a: assert property (gpio_active_out |-> $past(gpio_activate_in))
		else $error("gpio active without activate");
	cs_gate_a: assert property ((chip_select_out & ~$past(chip_select_match_in)) == 3'h0)
		else $error("chip select without match");
	clk_gate_a: assert property ((dev_clock_out[5:3] & ~$past(dev_clock_cfg_in[5:3])) == 3'h0)
		else $error("clock runs without device bit");
	mult_off_a: assert property ($fell(mult_enable_out) |=> !mult_clock_run_out)
		else $error("multiplier runs when disabled");
	mult_wait_a: assert property ($rose(mult_enable_out) |-> !mult_clock_run_out [*4])
		else $error("multiplier runs before stable");
	idx_upper_a: assert property ($past(idx_rd) |-> rdata_out[7:3] == 5'h00)
		else $error("index upper bits not zero");
	rsvd_idx_a: assert property ($past(dat_rd) && $past(idx) > 3'h4 |-> rdata_out == 8'h00)
		else $error("unassigned index not zero");
	rsvd_fen_a: assert property ($past(dat_rd) && $past(idx) == 3'h0 |-> !rdata_out[7] && !rdata_out[1])
		else $error("reserved enable bits not zero");
	rdata_hold_a: assert property (!$past(rd_hit) |-> $stable(rdata_out))
		else $error("read data moved without read");
	cover property ($rose(mult_clock_run_out));
	cover property (chip_select_out != 3'h0);
	cover property (dat_rd && idx == 3'h2);
endmodule // pmc_regs_props
bind pmc_regs pmc_regs_props #(.STABLE_CYCLES(STABLE_CYCLES)) u_props (.clock_in(clock_in), .nrst_in(nrst_in),
	.bus_in(bus_in), .base_addr_in(base_addr_in), .dev_activate_in(dev_activate_in),
	.gpio_activate_in(gpio_activate_in), .chip_select_match_in(chip_select_match_in),
	.dev_clock_cfg_in(dev_clock_cfg_in), .rdata_out(rdata_out), .dev_active_out(dev_active_out),
	.gpio_active_out(gpio_active_out), .chip_select_out(chip_select_out), .dev_clock_out(dev_clock_out),
	.mult_enable_out(mult_enable_out), .mult_clock_run_out(mult_clock_run_out));

// *** sim/tb_power_mgmt_config_regs.sv ***
// Self-checking bench for the power management register bank
module tb_power_mgmt_config_regs;
	timeunit 1ns;
	timeprecision 1ps;
	import pmc_pkg::*;
	logic clk = 1'b0, nrst = 1'b0, men, mrun, gact;
	logic osc = 1'b1, gpio_act = 1'b1;
	pmc_bus_t bus = '0;
	logic [15:0] base = 16'h02E0;
	logic [1:0] busy = 2'h0, csrc;
	logic [2:0] cs;
	logic [7:0] rdata;
	pmc_dev_t act = '1, flt = 6'h08, ckc = '1, dact, dflt, dclk;
	int fails = 0, cmp_count = 0;
	pmc_regs #(.STABLE_CYCLES(20)) uut (.clock_in(clk), .nrst_in(nrst), .bus_in(bus), .base_addr_in(base),
		.strap_clock_a_in(1'b1), .strap_clock_b_in(1'b1), .osc_running_in(osc), .dev_activate_in(act),
		.gpio_activate_in(gpio_act), .chip_select_match_in(3'h7), .dev_float_cfg_in(flt), .dev_clock_cfg_in(ckc),
		.uart_busy_in(busy), .rdata_out(rdata), .dev_active_out(dact), .gpio_active_out(gact),
		.chip_select_out(cs), .dev_float_out(dflt), .dev_clock_out(dclk), .clock_source_out(csrc),
		.mult_enable_out(men), .mult_clock_run_out(mrun));
	// Free-running clock, 5 ns period
	initial forever #2.5 clk = ~clk;
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// One host access, strobe held for one clock
	task automatic acc(input logic a0, input logic w, input logic [7:0] d);
		@(negedge clk);
		bus = '{base | {15'h0, a0}, !w, w, d};
		@(negedge clk);
		{bus.rd, bus.wr} = 2'h0;
	endtask
	task automatic ww(input logic [7:0] i, input logic [7:0] d);
		acc(1'b0, 1'b1, i);
		acc(1'b1, 1'b1, d);
	endtask
	task automatic rr(input logic [7:0] i, input logic [7:0] exp, input string nm);
		acc(1'b0, 1'b1, i);
		acc(1'b1, 1'b0, 8'h00);
		chk(nm, exp, rdata);
	endtask
	task automatic t_reset;
		rr(8'h03, 8'h07, "clock");
		acc(1'b0, 1'b0, 8'h00);
		chk("index", 8'h03, rdata);
		rr(8'h00, 8'h7D, "fen_a");
		rr(8'h01, 8'h87, "fen_b");
		rr(8'h02, 8'h00, "float");
		rr(8'h04, 8'h0E, "gate");
		$display("t_reset done");
	endtask
	task automatic t_index;
		acc(1'b0, 1'b1, 8'hFF);
		acc(1'b0, 1'b0, 8'h00);
		chk("index", 8'h07, rdata);
		rr(8'h05, 8'h00, "idx5");
		acc(1'b1, 1'b1, 8'hFF);
		acc(1'b1, 1'b0, 8'h00);
		chk("idx5w", 8'h00, rdata);
		base = 16'h0300;
		rr(8'h00, 8'h7D, "moved");
		$display("t_index done");
	endtask
	task automatic t_rw;
		logic [7:0] e1 [5] = '{8'h7D, 8'h87, 8'h78, 8'h87, 8'h8E};
		logic [7:0] e0 [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h40};
		busy = 2'h1;
		for (int i = 0; i < 5; i++) begin
			ww(8'(i), 8'hFF);
			rr(8'(i), e1[i], "ones");
		end
		busy = 2'h2;
		for (int i = 0; i < 5; i++) begin
			ww(8'(i), 8'h00);
			rr(8'(i), e0[i], "zeros");
		end
		$display("t_rw done");
	endtask
	task automatic t_gate;
		ww(8'h00, 8'h41);
		ww(8'h01, 8'h05);
		ww(8'h02, 8'h28);
		ww(8'h04, 8'h0A);
		ckc = 6'h1F;
		repeat (2) @(negedge clk);
		chk("active", 8'h21, {2'h0, dact});
		chk("cs", 8'h05, {5'h0, cs});
		chk("gpio", 8'h00, {7'h0, gact});
		chk("float", 8'h1C, {2'h0, dflt});
		chk("clk", 8'h01, {5'h0, dclk[5:3]});
		ww(8'h01, 8'h80);
		@(negedge clk);
		chk("gpio", 8'h01, {7'h0, gact});
		chk("cs", 8'h00, {5'h0, cs});
		gpio_act = 1'b0;
		@(negedge clk);
		chk("gpio_off", 8'h00, {7'h0, gact});
		gpio_act = 1'b1;
		$display("t_gate done");
	endtask
	task automatic t_mult;
		int n;
		ww(8'h03, 8'h02);
		@(negedge clk);
		chk("src", 8'h02, {6'h0, csrc});
		chk("men", 8'h00, {7'h0, men});
		osc = 1'b0;
		ww(8'h03, 8'h07);
		chk("frozen", 8'h00, {7'h0, mrun});
		rr(8'h03, 8'h07, "wait");
		repeat (30) @(negedge clk);
		chk("osc_hold", 8'h00, {7'h0, mrun});
		osc = 1'b1;
		for (n = 0; n < 100 && mrun !== 1'b1; n++) @(negedge clk);
		if (n == 100) begin
			fails++;
			$display("ERROR mult_timeout expected 1 seen %b", mrun);
		end
		rr(8'h03, 8'h87, "valid");
		$display("t_mult done");
	endtask
	task automatic print_verdict;
		$display("Comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Reset, then the scenarios in turn
	initial begin
		repeat (5) @(negedge clk);
		nrst = 1'b1;
		repeat (2) @(negedge clk);
		t_reset();
		t_index();
		t_rw();
		t_gate();
		t_mult();
		print_verdict();
	end
endmodule // tb_power_mgmt_config_regs
